/* hw/pwm_timer_pkg.sv */
package pwm_timer_pkg;
  // ----------------------------------------
  // register indices (8-bit data, byte map)
  // ----------------------------------------
  localparam logic [4:0] ADDR_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_COUNT_HIGH = 5'h01;
  localparam logic [4:0] ADDR_COUNT_LOW = 5'h02;
  localparam logic [4:0] ADDR_LIMIT_HIGH = 5'h03;
  localparam logic [4:0] ADDR_LIMIT_LOW = 5'h04;
  localparam logic [4:0] ADDR_CH_BASE = 5'h05;
  localparam logic [4:0] ADDR_SYS_CONTROL = 5'h11;
  localparam int CH_STRIDE = 3;
  // ----------------------------------------
  // timer status/control fields
  // ----------------------------------------
  localparam int SC_OVF = 7;
  localparam int SC_OVIE = 6;
  localparam int SC_HALT = 5;
  localparam int SC_CRST = 4;
  localparam logic [2:0] PS_EXTERNAL = 3'h7;
  localparam logic [7:0] SC_RESET = 8'h20;
  // ----------------------------------------
  // channel status/control fields
  // ----------------------------------------
  localparam int CC_FLAG = 7;
  localparam int CC_IE = 6;
  localparam int CC_MSB = 5;
  localparam int CC_MSA = 4;
  localparam int CC_ELSB = 3;
  localparam int CC_ELSA = 2;
  localparam int CC_TOV = 1;
  localparam int CC_MAX = 0;
  // ----------------------------------------
  // system control fields and resets
  // ----------------------------------------
  localparam int SYS_WAIT = 0;
  localparam int SYS_STOP = 1;
  localparam int SYS_BREAK = 2;
  localparam int SYS_BREAK_CLEAR_ENABLE = 3;
  localparam int SYS_PINDIR = 4;
  localparam logic [15:0] LIMIT_RESET = 16'hffff;
  localparam int NUM_CH = 4;
  localparam int PRESC_W = 6;
endpackage : pwm_timer_pkg

/* hw/tick_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler #(
  parameter int WIDTH = pwm_timer_pkg::PRESC_W
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic [2:0] select_in,
  input wire logic ext_clk_in,
  output logic tick_out
);
  // ----------------------------------------
  // divider and external clock sync
  // ----------------------------------------
  logic [WIDTH-1:0] div_r, div_nxt;
  logic sync1_r, sync2_r, sync3_r;
  logic tick;

  always_comb begin
    div_nxt = div_r;
    if (clear_in) begin
      div_nxt = '0;
    end else if (run_in) begin
      div_nxt = div_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_comb begin
    if (select_in == pwm_timer_pkg::PS_EXTERNAL) begin
      tick = sync2_r & ~sync3_r;
    end else if (select_in == 3'h0) begin
      tick = 1'b1;
    end else begin
      tick = div_r[select_in - 3'h1] & ~div_nxt[select_in - 3'h1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      div_r <= '0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      div_r <= div_nxt;
      sync1_r <= ext_clk_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      tick_out <= run_in & ~clear_in & tick;
    end
  end
endmodule : tick_prescaler
`default_nettype wire

/* hw/four_channel_pwm_timer.sv */
// How it works
// - edge/level 1:0 clears on compare, 1:1 sets; software picks complement level
// - buffered bit on ch0/ch2 links pair; even channel leads and governs
// - with clear on compare (1:0), toggle-on-wrap clear gives no wrap toggle, so 0% duty
// - full duty bit with toggle-on-wrap clear gives 100% duty
// - overflow flag sets when counter wraps from period limit to zero
// - overflow irq when flag and enable set; reset clears enable
// - channel flag on compare or capture; irq only with channel enable
// - wait mode keeps counting, blocks register access except system control writes, irq still requested
// - stop mode halts counter, prescaler and compares, keeps state, resumes after
// - break holds the counter
// - in break flags clear only with break clear enable
// - prescaler code 111 picks external clock pin, pin forced input
// - flag clears by read-with-set then write zero; new event blocks it
// - halt bit freezes counter; reset sets it
// - counter-reset bit clears counter and prescaler, self-clears, reads zero
// - halt plus counter-reset in one write leaves counter halted at zero
// - prescaler codes 000..110 divide by 1..64, 111 external; reset clears
// - wrap restarts from zero next tick; limit high write mutes flag till low
`timescale 1ns/1ps
`default_nettype none
module four_channel_pwm_timer #(
  parameter int NUM_CH = pwm_timer_pkg::NUM_CH
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic ext_clk_in,
  input wire logic [NUM_CH-1:0] ch_pin_in,
  output logic [NUM_CH-1:0] ch_pin_out,
  output logic [NUM_CH-1:0] ch_pin_oe_out,
  output logic ext_clk_oe_out,
  output logic irq_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] sc_r, sc_nxt;
  logic [4:0] sys_r, sys_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] lim_r, lim_nxt;
  logic mute_r, mute_nxt;
  logic ovf_armed_r, ovf_armed_nxt;
  logic [7:0] cc_r [NUM_CH];
  logic [7:0] cc_nxt [NUM_CH];
  logic [15:0] cv_r [NUM_CH];
  logic [15:0] cv_nxt [NUM_CH];
  logic [NUM_CH-1:0] arm_r, arm_nxt;
  logic [NUM_CH-1:0] out_r, out_nxt;
  logic [NUM_CH-1:0] pin1_r, pin2_r, pin3_r;
  logic [1:0] sel_r, sel_nxt;
  logic [1:0] pend_r, pend_nxt;
  logic [7:0] rdata_nxt;
  logic tick, crst, halt, wrap, acc, flag_ok;
  logic [NUM_CH-1:0] cmp_ev;
  logic [4:0] ch_a;

  function automatic logic [4:0] ch_addr(input int ch, input int ofs);
    ch_addr = 5'(int'(pwm_timer_pkg::ADDR_CH_BASE) + ch * pwm_timer_pkg::CH_STRIDE + ofs);
  endfunction : ch_addr

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  assign acc = ~sys_r[pwm_timer_pkg::SYS_WAIT];
  assign flag_ok = ~sys_r[pwm_timer_pkg::SYS_BREAK] | sys_r[pwm_timer_pkg::SYS_BREAK_CLEAR_ENABLE];
  assign crst = acc & wr_in & (addr_in == pwm_timer_pkg::ADDR_STATUS_CONTROL) &
    wdata_in[pwm_timer_pkg::SC_CRST];
  assign halt = sc_r[pwm_timer_pkg::SC_HALT] | sys_r[pwm_timer_pkg::SYS_STOP] |
    sys_r[pwm_timer_pkg::SYS_BREAK];
  assign wrap = tick & (cnt_r == lim_r);
  assign ext_clk_oe_out = sc_r[2:0] != pwm_timer_pkg::PS_EXTERNAL &&
    sys_r[pwm_timer_pkg::SYS_PINDIR];

  tick_prescaler tick_prescaler_inst (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clear_in(crst),
    .run_in(~halt),
    .select_in(sc_r[2:0]),
    .ext_clk_in(ext_clk_in),
    .tick_out(tick)
  );

  // ----------------------------------------
  // counter and overflow
  // ----------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    sc_nxt = sc_r;
    sys_nxt = sys_r;
    lim_nxt = lim_r;
    mute_nxt = mute_r;
    ovf_armed_nxt = ovf_armed_r;
    if (crst) begin
      cnt_nxt = '0;
    end else if (tick & ~halt) begin
      cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;
    end
    if (acc & rd_in & addr_in == pwm_timer_pkg::ADDR_STATUS_CONTROL &
        sc_r[pwm_timer_pkg::SC_OVF] & flag_ok) begin
      ovf_armed_nxt = 1'b1;
    end
    if (acc & wr_in) begin
      case (addr_in)
        pwm_timer_pkg::ADDR_STATUS_CONTROL: begin
          sc_nxt[6:0] = {wdata_in[6:5], 1'b0, 1'b0, wdata_in[2:0]};
          if (~wdata_in[pwm_timer_pkg::SC_OVF] & ovf_armed_r & flag_ok) begin
            sc_nxt[pwm_timer_pkg::SC_OVF] = 1'b0;
            ovf_armed_nxt = 1'b0;
          end
        end
        pwm_timer_pkg::ADDR_LIMIT_HIGH: begin
          lim_nxt[15:8] = wdata_in;
          mute_nxt = 1'b1;
        end
        pwm_timer_pkg::ADDR_LIMIT_LOW: begin
          lim_nxt[7:0] = wdata_in;
          mute_nxt = 1'b0;
        end
        pwm_timer_pkg::ADDR_SYS_CONTROL: sys_nxt = wdata_in[4:0];
        default: begin
        end
      endcase
    end else if (wr_in & addr_in == pwm_timer_pkg::ADDR_SYS_CONTROL) begin
      sys_nxt = wdata_in[4:0];
    end
    if (wrap & ~halt & ~crst & ~mute_r) begin
      sc_nxt[pwm_timer_pkg::SC_OVF] = 1'b1;
      ovf_armed_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  always_comb begin
    arm_nxt = arm_r;
    out_nxt = out_r;
    sel_nxt = sel_r;
    pend_nxt = pend_r;
    cmp_ev = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      cc_nxt[i] = cc_r[i];
      cv_nxt[i] = cv_r[i];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      logic lead, slave, outm, tog;
      lead = (i % 2 == 0) && cc_r[i][pwm_timer_pkg::CC_MSB];
      slave = (i % 2 == 1) && cc_r[i-1 + (i % 2 == 0)][pwm_timer_pkg::CC_MSB];
      outm = (lead | cc_r[i][pwm_timer_pkg::CC_MSA]) & ~slave;
      tog = cc_r[i][pwm_timer_pkg::CC_TOV];
      if (outm & tick & ~halt &
          cnt_r == cv_r[lead && sel_r[i/2] ? i+1 : i]) begin
        cmp_ev[i] = 1'b1;
        case (cc_r[i][3:2])
          2'b01: out_nxt[i] = ~out_r[i];
          2'b10: out_nxt[i] = 1'b0;
          2'b11: out_nxt[i] = 1'b1;
          default: out_nxt[i] = out_r[i];
        endcase
      end
      if (outm & wrap & ~halt & ~crst) begin
        if (tog) begin
          out_nxt[i] = ~out_r[i];
        end
        if (lead && pend_r[i/2]) begin
          sel_nxt[i/2] = ~sel_r[i/2];
          pend_nxt[i/2] = 1'b0;
        end
      end
      if (outm & cc_r[i][pwm_timer_pkg::CC_MAX] & ~tog) begin
        out_nxt[i] = 1'b1;
      end
      if (~cc_r[i][pwm_timer_pkg::CC_MSA] & ~cc_r[i][pwm_timer_pkg::CC_MSB] &
          (cc_r[i][3:2] != 2'b00)) begin
        if (cc_r[i][3:2] == 2'b01 && pin2_r[i] & ~pin3_r[i] ||
            cc_r[i][3:2] == 2'b10 && ~pin2_r[i] & pin3_r[i] ||
            cc_r[i][3:2] == 2'b11 && pin2_r[i] != pin3_r[i]) begin
          cmp_ev[i] = 1'b1;
          cv_nxt[i] = cnt_r;
        end
      end
      ch_a = ch_addr(i, 0);
      if (acc & rd_in & addr_in == ch_a & cc_r[i][pwm_timer_pkg::CC_FLAG] & flag_ok) begin
        arm_nxt[i] = 1'b1;
      end
      if (acc & wr_in) begin
        if (addr_in == ch_a) begin
          cc_nxt[i][6:0] = wdata_in[6:0];
          if (i % 2 == 1) begin
            cc_nxt[i][pwm_timer_pkg::CC_MSB] = 1'b0;
          end
          if (~wdata_in[pwm_timer_pkg::CC_FLAG] & arm_r[i] & flag_ok) begin
            cc_nxt[i][pwm_timer_pkg::CC_FLAG] = 1'b0;
            arm_nxt[i] = 1'b0;
          end
        end
        if (addr_in == ch_addr(i, 1)) begin
          cv_nxt[i][15:8] = wdata_in;
        end
        if (addr_in == ch_addr(i, 2)) begin
          cv_nxt[i][7:0] = wdata_in;
          if (i % 2 == 1) begin
            pend_nxt[i/2] = sel_r[i/2] == 1'b0;
          end else begin
            pend_nxt[i/2] = sel_r[i/2] == 1'b1;
          end
        end
      end
      if (cmp_ev[i]) begin
        cc_nxt[i][pwm_timer_pkg::CC_FLAG] = 1'b1;
        arm_nxt[i] = 1'b0;
      end
      if (~cc_r[i][pwm_timer_pkg::CC_MSB] && i % 2 == 0) begin
        sel_nxt[i/2] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read path and outputs
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (addr_in == ch_addr(i, 0)) rdata_nxt = cc_r[i];
      if (addr_in == ch_addr(i, 1)) rdata_nxt = cv_r[i][15:8];
      if (addr_in == ch_addr(i, 2)) rdata_nxt = cv_r[i][7:0];
    end
    case (addr_in)
      pwm_timer_pkg::ADDR_STATUS_CONTROL: rdata_nxt = sc_r;
      pwm_timer_pkg::ADDR_COUNT_HIGH: rdata_nxt = cnt_r[15:8];
      pwm_timer_pkg::ADDR_COUNT_LOW: rdata_nxt = cnt_r[7:0];
      pwm_timer_pkg::ADDR_LIMIT_HIGH: rdata_nxt = lim_r[15:8];
      pwm_timer_pkg::ADDR_LIMIT_LOW: rdata_nxt = lim_r[7:0];
      pwm_timer_pkg::ADDR_SYS_CONTROL: rdata_nxt = {3'h0, sys_r};
      default: begin
      end
    endcase
    if (~rd_in | ~acc) rdata_nxt = 8'h00;
  end

  always_comb begin
    irq_out = sc_r[pwm_timer_pkg::SC_OVF] & sc_r[pwm_timer_pkg::SC_OVIE];
    for (int i = 0; i < NUM_CH; i++) begin
      ch_pin_oe_out[i] = (cc_r[i][3:2] != 2'b00) & (cc_r[i][pwm_timer_pkg::CC_MSA] |
        ((i % 2 == 0) & cc_r[i][pwm_timer_pkg::CC_MSB])) &
        ~((i % 2 == 1) & cc_r[i - (i % 2)][pwm_timer_pkg::CC_MSB]);
      irq_out = irq_out | (cc_r[i][pwm_timer_pkg::CC_FLAG] & cc_r[i][pwm_timer_pkg::CC_IE]);
    end
    ch_pin_out = out_r;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sc_r <= pwm_timer_pkg::SC_RESET;
      sys_r <= '0;
      cnt_r <= '0;
      lim_r <= pwm_timer_pkg::LIMIT_RESET;
      mute_r <= 1'b0;
      ovf_armed_r <= 1'b0;
      arm_r <= '0;
      out_r <= '0;
      sel_r <= '0;
      pend_r <= '0;
      pin1_r <= '0;
      pin2_r <= '0;
      pin3_r <= '0;
      rdata_out <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        cc_r[i] <= 8'h00;
        cv_r[i] <= 16'h0000;
      end
    end else begin
      sc_r <= sc_nxt;
      sys_r <= sys_nxt;
      cnt_r <= cnt_nxt;
      lim_r <= lim_nxt;
      mute_r <= mute_nxt;
      ovf_armed_r <= ovf_armed_nxt;
      arm_r <= arm_nxt;
      out_r <= out_nxt;
      sel_r <= sel_nxt;
      pend_r <= pend_nxt;
      pin1_r <= ch_pin_in;
      pin2_r <= pin1_r;
      pin3_r <= pin2_r;
      rdata_out <= rdata_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        cc_r[i] <= cc_nxt[i];
        cv_r[i] <= cv_nxt[i];
      end
    end
  end
endmodule : four_channel_pwm_timer
`default_nettype wire

/* tb/pwm_timer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic ext_clk_oe_out,
  input wire logic irq_out
);
  // ------------------------------
  // shared sequences
  // ------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence st_rd;
    rd_in && addr_in == pwm_timer_pkg::ADDR_STATUS_CONTROL;
  endsequence
  sequence lo_rd;
    rd_in && addr_in == pwm_timer_pkg::ADDR_COUNT_LOW;
  endsequence
  sequence st_wr(logic [1:0] hc);
    wr_in && addr_in == pwm_timer_pkg::ADDR_STATUS_CONTROL && wdata_in[5:4] == hc;
  endsequence
  property halt_freeze_p;
    logic [7:0] v;
    st_wr(2'b10) ##2 lo_rd ##1 (1'b1, v = rdata_out) ##1 lo_rd |=> rdata_out == v;
  endproperty
  // ------------------------------
  // assertions
  // ------------------------------
  chk_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  chk_crst_reads_zero: assert property (st_rd |=> !rdata_out[pwm_timer_pkg::SC_CRST])
    else $error("counter reset bit read as one");
  chk_clear_restart: assert property (st_wr(2'b01) ##2 lo_rd |=> rdata_out <= 8'h01)
    else $error("counter not restarted from zero");
  chk_halt_clear_zero: assert property (st_wr(2'b11) ##2 lo_rd |=> rdata_out == 8'h00)
    else $error("halt with clear did not leave zero");
  chk_halt_freeze_count: assert property (halt_freeze_p)
    else $error("counter moved while halted");
  chk_ext_pin_input: assert property (st_rd ##1 rdata_out[2:0] == 3'h7 |-> !ext_clk_oe_out)
    else $error("clock pin driven while selected as clock");
  chk_ovf_irq_raise: assert property (st_rd ##1 (rdata_out[7] && rdata_out[6]) |-> irq_out)
    else $error("overflow request missing");
  chk_ch_irq_raise: assert property ((rd_in && addr_in == pwm_timer_pkg::ADDR_CH_BASE) ##1
      (rdata_out[7] && rdata_out[6]) |-> irq_out)
    else $error("channel request missing");
  cover property (st_rd ##1 rdata_out[7]);
  cover property (irq_out);
  cover property (wr_in && addr_in == pwm_timer_pkg::ADDR_SYS_CONTROL);
endmodule : pwm_timer_checker
`default_nettype wire

/* tb/test_four_channel_pwm_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_four_channel_pwm_timer;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic [3:0] ch_pin_in = 4'h0;
  logic [7:0] rdata_out;
  logic [3:0] ch_pin_out;
  logic [3:0] ch_pin_oe_out;
  logic ext_clk_oe_out;
  logic irq_out;
  int mismatches = 0;
  int checked = 0;
  always #2.5 clk_in = ~clk_in;
  four_channel_pwm_timer four_channel_pwm_timer_inst (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_clk_in(ext_clk_in), .ch_pin_in(ch_pin_in),
    .ch_pin_out(ch_pin_out), .ch_pin_oe_out(ch_pin_oe_out),
    .ext_clk_oe_out(ext_clk_oe_out), .irq_out(irq_out));
  // ------------------------------
  // bus tasks
  // ------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    v = rdata_out;
    @(posedge clk_in);
  endtask : rd
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_ovf;
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 40 && v[7] !== 1'b1; k++) begin
      rd(5'h00, v);
    end
    `CHK(v[7], 1'b1)
    if (v[7] !== 1'b1) begin
      end_of_test();
    end
  endtask : wait_ovf
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset;
    logic [7:0] v;
    rd(5'h00, v);
    `CHK(v, 8'h20)
    rd(5'h03, v);
    `CHK(v, 8'hff)
    rd(5'h1f, v);
    `CHK(v, 8'h00)
    `CHK(irq_out, 1'b0)
  endtask : t_reset
  task automatic t_prescale;
    logic [7:0] v;
    logic [7:0] w;
    int e;
    for (int c = 0; c < 7; c++) begin
      wr(5'h00, 8'h10 | 8'(c));
      rd(5'h02, v);
      `CHK(v <= 8'h01, 1'b1)
      repeat (200) @(posedge clk_in);
      wr(5'h00, 8'h20 | 8'(c));
      rd(5'h02, v);
      rd(5'h02, w);
      `CHK(w, v)
      e = 203 >> c;
      `CHK(v + 8'd3 >= 8'(e) && v <= 8'(e + 3), 1'b1)
    end
  endtask : t_prescale
  task automatic t_ext;
    logic [7:0] v;
    wr(5'h11, 8'h10);
    wr(5'h00, 8'h37);
    rd(5'h02, v);
    `CHK(v, 8'h00)
    wr(5'h00, 8'h07);
    rd(5'h00, v);
    `CHK(ext_clk_oe_out, 1'b0)
    repeat (10) begin
      ext_clk_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      ext_clk_in <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    wr(5'h00, 8'h20);
    rd(5'h02, v);
    `CHK(v >= 8'h09 && v <= 8'h0a, 1'b1)
    `CHK(ext_clk_oe_out, 1'b1)
  endtask : t_ext
  task automatic t_ovf;
    logic [7:0] v;
    wr(5'h00, 8'h30);
    wr(5'h03, 8'h00);
    wr(5'h04, 8'h05);
    wr(5'h00, 8'h00);
    wait_ovf();
    `CHK(irq_out, 1'b0)
    wr(5'h00, 8'hc0);
    rd(5'h00, v);
    `CHK(v, 8'hc0)
    `CHK(irq_out, 1'b1)
    repeat (8) @(posedge clk_in);
    wr(5'h00, 8'h60);
    rd(5'h00, v);
    `CHK(v, 8'he0)
    wr(5'h00, 8'h60);
    rd(5'h00, v);
    `CHK(v, 8'h60)
    `CHK(irq_out, 1'b0)
    wr(5'h03, 8'h00);
    wr(5'h00, 8'h40);
    repeat (20) @(posedge clk_in);
    rd(5'h00, v);
    `CHK(v[7], 1'b0)
    wr(5'h04, 8'h05);
    wait_ovf();
  endtask : t_ovf
  task automatic t_modes;
    logic [7:0] v;
    logic [7:0] w;
    wr(5'h11, 8'h04);
    rd(5'h02, v);
    repeat (8) @(posedge clk_in);
    rd(5'h02, w);
    `CHK(w, v)
    rd(5'h00, v);
    wr(5'h00, 8'h40);
    rd(5'h00, v);
    `CHK(v[7], 1'b1)
    wr(5'h11, 8'h0c);
    rd(5'h00, v);
    wr(5'h00, 8'h40);
    rd(5'h00, v);
    `CHK(v[7], 1'b0)
    wr(5'h11, 8'h02);
    rd(5'h02, v);
    repeat (8) @(posedge clk_in);
    rd(5'h02, w);
    `CHK(w, v)
    wr(5'h11, 8'h01);
    wr(5'h00, 8'h20);
    wr(5'h11, 8'h00);
    rd(5'h00, v);
    `CHK(v[5], 1'b0)
  endtask : t_modes
  task automatic t_pwm;
    logic [7:0] v;
    int hi;
    int k;
    logic [7:0] ctl [5] = '{8'h5a, 8'h18, 8'h19, 8'h1a, 8'h3a};
    int lo_b [5] = '{30, 0, 100, 30, 30};
    int hi_b [5] = '{60, 0, 100, 60, 60};
    for (int i = 0; i < 5; i++) begin
      k = (i == 4) ? 2 : i;
      wr(5'h00, 8'h30);
      wr(5'h03, 8'h00);
      wr(5'h04, 8'h09);
      wr(5'(6 + 3 * k), 8'h00);
      wr(5'(7 + 3 * k), 8'h04);
      wr(5'(5 + 3 * k), ctl[i]);
      wr(5'h00, 8'h00);
      repeat (20) @(posedge clk_in);
      hi = 0;
      repeat (100) begin
        @(negedge clk_in);
        hi += int'(ch_pin_out[k] === 1'b1);
      end
      @(posedge clk_in);
      `CHK(hi >= lo_b[i] && hi <= hi_b[i], 1'b1)
    end
    `CHK(ch_pin_oe_out, 4'h7)
    rd(5'h05, v);
    `CHK(v[7], 1'b1)
    `CHK(irq_out, 1'b1)
  endtask : t_pwm
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_prescale();
    t_ext();
    t_ovf();
    t_modes();
    t_pwm();
    end_of_test();
  end
endmodule : test_four_channel_pwm_timer
bind four_channel_pwm_timer pwm_timer_checker pwm_timer_checker_inst (.clk_in(clk_in),
  .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .ext_clk_oe_out(ext_clk_oe_out), .irq_out(irq_out));
`default_nettype wire
